// ### design/i2sp_slave.sv
// Purpose: I2C slave-only serial port with register access
// Assumes: mclk 40 MHz; SCL and SDA arrive asynchronously
// Notes: Open-drain pins, plain register port, slave only
// Operation
// - SDA and SCL only pulled low or released, never driven high
// - No chip select; selection is by matching the bus address
// - Slave only: slave transmit and slave receive directions
// - Optional SCL filter rejects glitches shorter than 2 or 4 clocks
// - Debounce select 00 none, 01 two clocks, 1x four clocks
// - One shared 8-bit data register carries every byte both ways
// - Address register bits 7..1 hold own address, bit 0 reserved RW
// - Selected when master address equals own address
// - Address register shares its location with the SPI control register
// - Debounce select acts only while function select is 110
// - Mode control bit 4 reads as zero
// - Pull-up control stays writable while I2C is active
// - Status register shows flags; separate time-out control register
// - Enable rising with function select 110 resets flags, keeps direction and ack controls
`timescale 1ns/1ps
`include "i2sp_defs.svh"
module i2sp_slave (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  input wire logic scl_in,
  output logic scl_out_ff,
  output logic scl_oe_ff,
  input wire logic sda_in,
  output logic sda_out_ff,
  output logic sda_oe_ff,
  output logic [1:0] pullup_en_ff,
  output logic irq_ff
);
  // ==========================================
  // Registers
  logic [7:0] mode_ff, addr_ff, data_ff, tout_ff;
  logic [1:0] pull_ff;
  logic [2:0] ist_ff, imask_ff;
  logic tx_dir_ff, ack_send_ff, wake_ff;
  i2sp_pkg::i2sp_flags_type flg_ff;
  i2sp_pkg::i2sp_state_type st_ff, nxt_st;
  logic [2:0] scl_s_ff, sda_s_ff;
  logic scl_f_ff, scl_fd_ff, sda_d_ff;
  logic [2:0] deb_cnt_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shf_ff;
  logic en_d_ff;

  // ==========================================
  // Decoding
  wire en = mode_ff[1];
  wire i2c_on = en && (mode_ff[7:5] == `I2SP_FN_I2C);
  wire [2:0] deb_len = !i2c_on ? 3'h0 :
    mode_ff[3] ? `I2SP_DEB_LONG : mode_ff[2] ? `I2SP_DEB_SHORT : 3'h0;
  wire wr_mode = reg_wr && reg_addr == `I2SP_OFS_MODE;
  wire wr_stat = reg_wr && reg_addr == `I2SP_OFS_STAT;
  wire wr_data = reg_wr && reg_addr == `I2SP_OFS_DATA;
  wire wr_addr = reg_wr && reg_addr == `I2SP_OFS_ADDR;
  wire wr_tout = reg_wr && reg_addr == `I2SP_OFS_TOUT;
  wire wr_ist = reg_wr && reg_addr == `I2SP_OFS_IRQ_STAT;
  wire wr_imsk = reg_wr && reg_addr == `I2SP_OFS_IRQ_MASK;
  wire wr_pull = reg_wr && reg_addr == `I2SP_OFS_PULLUP;
  wire scl_raw = scl_s_ff[1];
  wire sda_now = sda_s_ff[1];
  wire scl_rise = scl_f_ff && !scl_fd_ff;
  wire scl_fall = !scl_f_ff && scl_fd_ff;
  wire start_ev = i2c_on && scl_raw && scl_f_ff && sda_d_ff && !sda_now;
  wire stop_ev = i2c_on && scl_raw && scl_f_ff && !sda_d_ff && sda_now;
  wire en_rise = en && !en_d_ff;
  wire last_bit = bit_cnt_ff == 4'h7;
  wire addr_hit = shf_ff[7:1] == addr_ff[7:1];
  wire addr_done = st_ff == i2sp_pkg::ST_ADDR && scl_fall && last_bit;
  wire rx_done = st_ff == i2sp_pkg::ST_RX && scl_fall && last_bit;
  wire [7:0] stat_rd = {flg_ff.byte_done_flag, flg_ff.address_match_flag,
    flg_ff.bus_busy_flag, tx_dir_ff, ack_send_ff, flg_ff.master_read_request,
    wake_ff, flg_ff.ack_received};
  wire [7:0] rd_mux =
    reg_addr == `I2SP_OFS_MODE ? {mode_ff[7:5], 1'b0, mode_ff[3:0]} :
    reg_addr == `I2SP_OFS_STAT ? stat_rd :
    reg_addr == `I2SP_OFS_DATA ? data_ff :
    reg_addr == `I2SP_OFS_ADDR ? addr_ff :
    reg_addr == `I2SP_OFS_TOUT ? tout_ff :
    reg_addr == `I2SP_OFS_IRQ_STAT ? {5'h00, ist_ff} :
    reg_addr == `I2SP_OFS_IRQ_MASK ? {5'h00, imask_ff} :
    reg_addr == `I2SP_OFS_PULLUP ? {6'h00, pull_ff} : 8'h00;

  // ==========================================
  // Input synchronisers and SCL filter
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
      sda_d_ff <= 1'b1;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], scl_in};
      sda_s_ff <= {sda_s_ff[1:0], sda_in};
      sda_d_ff <= sda_now;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_f_ff <= 1'b1;
      scl_fd_ff <= 1'b1;
      deb_cnt_ff <= 3'h0;
    end else begin
      scl_fd_ff <= scl_f_ff;
      if (scl_raw == scl_f_ff) begin
        deb_cnt_ff <= 3'h0;
      end else if (deb_cnt_ff + 3'h1 >= deb_len) begin
        scl_f_ff <= scl_raw;
        deb_cnt_ff <= 3'h0;
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 3'h1;
      end
    end
  end

  // ==========================================
  // Slave engine
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      i2sp_pkg::ST_IDLE: nxt_st = st_ff;
      i2sp_pkg::ST_ADDR: if (scl_fall && last_bit) nxt_st = addr_hit ?
        i2sp_pkg::ST_ACK : i2sp_pkg::ST_WAIT;
      i2sp_pkg::ST_ACK: if (scl_fall) nxt_st = (flg_ff.master_read_request || tx_dir_ff) ?
        i2sp_pkg::ST_TX : i2sp_pkg::ST_RX;
      i2sp_pkg::ST_TX: if (scl_fall && last_bit) nxt_st = i2sp_pkg::ST_MACK;
      i2sp_pkg::ST_RX: if (scl_fall && last_bit) nxt_st = i2sp_pkg::ST_ACK;
      i2sp_pkg::ST_MACK: if (scl_fall) nxt_st = flg_ff.ack_received ?
        i2sp_pkg::ST_WAIT : i2sp_pkg::ST_TX;
      i2sp_pkg::ST_WAIT: nxt_st = st_ff;
      default: nxt_st = i2sp_pkg::ST_IDLE;
    endcase
    if (start_ev) nxt_st = i2sp_pkg::ST_ADDR;
    if (stop_ev || !i2c_on) nxt_st = i2sp_pkg::ST_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff <= i2sp_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shf_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      if (start_ev) begin
        bit_cnt_ff <= 4'hf;
      end else if (scl_fall && (last_bit || st_ff == i2sp_pkg::ST_ACK ||
          st_ff == i2sp_pkg::ST_MACK)) begin
        bit_cnt_ff <= 4'h0;
      end else if (scl_fall) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (scl_rise && (st_ff == i2sp_pkg::ST_ADDR || st_ff == i2sp_pkg::ST_RX)) begin
        shf_ff <= {shf_ff[6:0], sda_now};
      end else if (st_ff == i2sp_pkg::ST_ACK && scl_fall && nxt_st == i2sp_pkg::ST_TX) begin
        shf_ff <= data_ff;
      end else if (st_ff == i2sp_pkg::ST_MACK && scl_fall) begin
        shf_ff <= data_ff;
      end else if (st_ff == i2sp_pkg::ST_TX && scl_fall) begin
        shf_ff <= {shf_ff[6:0], 1'b1};
      end
    end
  end

  // ==========================================
  // Open-drain pins: drive low or release only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_out_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
      scl_out_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      if (nxt_st == i2sp_pkg::ST_ACK) begin
        sda_oe_ff <= (st_ff == i2sp_pkg::ST_ADDR) ? 1'b1 : !ack_send_ff;
      end else if (nxt_st == i2sp_pkg::ST_TX) begin
        if (st_ff != i2sp_pkg::ST_TX) begin
          sda_oe_ff <= !data_ff[7];
        end else begin
          sda_oe_ff <= scl_fall ? !shf_ff[6] : !shf_ff[7];
        end
      end else begin
        sda_oe_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // Registers, flags and interrupt
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_ff <= `I2SP_RST_MODE;
      addr_ff <= `I2SP_RST_ADDR;
      data_ff <= `I2SP_RST_DATA;
      tout_ff <= `I2SP_RST_TOUT;
      pull_ff <= 2'h0;
      tx_dir_ff <= 1'b0;
      ack_send_ff <= 1'b0;
      wake_ff <= 1'b0;
      flg_ff <= 5'b10001;
      ist_ff <= 3'h0;
      imask_ff <= 3'h0;
      en_d_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
      pullup_en_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      en_d_ff <= en;
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
      pullup_en_ff <= pull_ff;
      irq_ff <= |(ist_ff & imask_ff);
      if (wr_mode) mode_ff <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
      if (wr_addr) addr_ff <= reg_wdata;
      if (wr_tout) tout_ff <= reg_wdata;
      if (wr_pull) pull_ff <= reg_wdata[1:0];
      if (wr_imsk) imask_ff <= reg_wdata[2:0];
      if (wr_stat) begin
        tx_dir_ff <= reg_wdata[4];
        ack_send_ff <= reg_wdata[3];
        wake_ff <= reg_wdata[1];
      end
      if (st_ff == i2sp_pkg::ST_RX && scl_fall && last_bit) begin
        data_ff <= shf_ff;
      end else if (st_ff == i2sp_pkg::ST_ADDR && scl_fall && last_bit && addr_hit) begin
        data_ff <= shf_ff;
      end else if (wr_data) begin
        data_ff <= reg_wdata;
      end
      if (en_rise && i2c_on) begin
        flg_ff <= 5'b10001;
      end else begin
        if (start_ev) flg_ff.bus_busy_flag <= 1'b1;
        if (stop_ev) flg_ff.bus_busy_flag <= 1'b0;
        if (start_ev) flg_ff.address_match_flag <= 1'b0;
        if (scl_fall && last_bit) flg_ff.byte_done_flag <= 1'b1;
        else if (scl_fall) flg_ff.byte_done_flag <= 1'b0;
        if (st_ff == i2sp_pkg::ST_ADDR && scl_fall && last_bit) begin
          flg_ff.address_match_flag <= addr_hit;
          flg_ff.master_read_request <= shf_ff[0];
        end
        if (st_ff == i2sp_pkg::ST_MACK && scl_rise) flg_ff.ack_received <= sda_now;
      end
      ist_ff <= (wr_ist ? ist_ff & ~reg_wdata[2:0] : ist_ff) | {stop_ev,
        st_ff == i2sp_pkg::ST_ADDR && scl_fall && last_bit && addr_hit,
        scl_fall && last_bit && st_ff != i2sp_pkg::ST_ADDR};
    end
  end

  // ==========================================
  // Checks
  a_mode_bit4_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && reg_addr == `I2SP_OFS_MODE
    |=> !reg_rdata_ff[4])
    else $error("Mode bit 4 read nonzero");

  a_sda_open_drain: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |-> !sda_out_ff && !scl_out_ff)
    else $error("Pin driven high");

  a_no_deb_off: assert property (@(posedge mclk) disable iff (!rst_b)
    !i2c_on && scl_raw != scl_f_ff
    |=> scl_f_ff == $past(scl_raw))
    else $error("Filter active outside I2C mode");

  a_deb_long_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    i2c_on && mode_ff[3] && $changed(scl_f_ff)
    |-> $past(scl_raw, 1) == $past(scl_raw, 4))
    else $error("Long debounce too short");

  a_addr_match: assert property (@(posedge mclk) disable iff (!rst_b)
    addr_done && !start_ev && !stop_ev
    |=> flg_ff.address_match_flag == (shf_ff[7:1] == addr_ff[7:1]) || $past(en_rise))
    else $error("Address match flag wrong");

  a_addr_bit0_rw: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_addr
    |=> addr_ff == $past(reg_wdata))
    else $error("Address register write lost");

  a_en_rise_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    en_rise && i2c_on && !wr_stat
    |=> flg_ff == 5'b10001 && tx_dir_ff == $past(tx_dir_ff))
    else $error("Enable rise flag reset wrong");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
    |(ist_ff & imask_ff)
    |=> irq_ff)
    else $error("Interrupt not raised");

  a_irq_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    !(|(ist_ff & imask_ff))
    |=> !irq_ff)
    else $error("Interrupt raised with nothing pending");

  a_scl_no_stretch: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |-> !scl_oe_ff)
    else $error("Clock line pulled low by slave");

  a_oe_in_ack_tx: assert property (@(posedge mclk) disable iff (!rst_b)
    sda_oe_ff
    |-> st_ff == i2sp_pkg::ST_ACK || st_ff == i2sp_pkg::ST_TX)
    else $error("Data line pulled outside ack or transmit");

  a_hit_to_ack: assert property (@(posedge mclk) disable iff (!rst_b)
    addr_done && addr_hit && !start_ev && !stop_ev && i2c_on
    |=> st_ff == i2sp_pkg::ST_ACK)
    else $error("Matched address not acknowledged");

  a_miss_to_wait: assert property (@(posedge mclk) disable iff (!rst_b)
    addr_done && !addr_hit && !start_ev && !stop_ev && i2c_on
    |=> st_ff == i2sp_pkg::ST_WAIT)
    else $error("Foreign address selected the slave");

  a_rw_capture: assert property (@(posedge mclk) disable iff (!rst_b)
    addr_done
    |=> flg_ff.master_read_request == $past(shf_ff[0]) || $past(en_rise))
    else $error("Direction bit not captured");

  a_rx_store: assert property (@(posedge mclk) disable iff (!rst_b)
    rx_done
    |=> data_ff == $past(shf_ff))
    else $error("Received byte not stored");

  a_data_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_data && !rx_done && !(addr_done && addr_hit)
    |=> data_ff == $past(reg_wdata))
    else $error("Data register write lost");

  a_tx_first_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    st_ff == i2sp_pkg::ST_ACK && scl_fall && nxt_st == i2sp_pkg::ST_TX
    |=> sda_oe_ff == !$past(data_ff[7]))
    else $error("First transmit bit not from data register");

  a_idle_when_off: assert property (@(posedge mclk) disable iff (!rst_b)
    !i2c_on
    |=> st_ff == i2sp_pkg::ST_IDLE)
    else $error("Engine active outside I2C function");

  a_deb_short_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    i2c_on && mode_ff[3:2] == 2'b01 && $changed(scl_f_ff)
    |-> $past(scl_raw, 1) == $past(scl_raw, 2))
    else $error("Short debounce too short");

  a_busy_start: assert property (@(posedge mclk) disable iff (!rst_b)
    start_ev && !en_rise
    |=> flg_ff.bus_busy_flag)
    else $error("Busy flag not set by start");

  a_busy_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    stop_ev && !en_rise
    |=> !flg_ff.bus_busy_flag)
    else $error("Busy flag not cleared by stop");

  a_stat_ctrl_rw: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_stat
    |=> tx_dir_ff == $past(reg_wdata[4]) && ack_send_ff == $past(reg_wdata[3]))
    else $error("Direction or ack control write lost");

  a_mode_bit4_store: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_mode
    |=> !mode_ff[4])
    else $error("Mode bit 4 stored");

  a_pullup_follow: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_pull
    |=> ##1 pullup_en_ff == $past(reg_wdata[1:0], 2))
    else $error("Pull-up enable not updated");

  a_addr_irq_set: assert property (@(posedge mclk) disable iff (!rst_b)
    addr_done && addr_hit
    |=> ist_ff[`I2SP_IRQ_ADDR])
    else $error("Address interrupt status not set");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd
    |=> reg_rdata_ff == 8'h00)
    else $error("Read data not zero outside read");
endmodule : i2sp_slave

// ### design/i2sp_defs.svh
// Purpose: Register offsets, field positions, reset values and counts for the I2C slave port
// Assumes: Included by its bare name
// Notes: Offsets are byte addresses on the plain register port
`ifndef I2SP_DEFS_SVH
`define I2SP_DEFS_SVH
// ==========================================
// Register offsets
`define I2SP_OFS_MODE 8'h00
`define I2SP_OFS_STAT 8'h04
`define I2SP_OFS_DATA 8'h08
`define I2SP_OFS_ADDR 8'h0c
`define I2SP_OFS_TOUT 8'h10
`define I2SP_OFS_IRQ_STAT 8'h14
`define I2SP_OFS_IRQ_MASK 8'h18
`define I2SP_OFS_PULLUP 8'h1c
// ==========================================
// Reset values
`define I2SP_RST_MODE 8'he0
`define I2SP_RST_ADDR 8'h00
`define I2SP_RST_DATA 8'h00
`define I2SP_RST_TOUT 8'h00
// ==========================================
// Function codes and debounce counts
`define I2SP_FN_I2C 3'h6
`define I2SP_DEB_SHORT 3'h2
`define I2SP_DEB_LONG 3'h4
// ==========================================
// Interrupt status bit positions
`define I2SP_IRQ_BYTE 0
`define I2SP_IRQ_ADDR 1
`define I2SP_IRQ_STOP 2
`endif

// ### design/i2sp_pkg.sv
// Purpose: Types for the I2C slave port
// Assumes: Used by full package scope, never imported
// Notes: Holds the state encoding and the flag group
package i2sp_pkg;
  // ==========================================
  // Slave engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_RX = 3'b100,
    ST_MACK = 3'b101,
    ST_WAIT = 3'b110
  } i2sp_state_type;
  // ==========================================
  // Bus status flags
  typedef struct packed {
    logic byte_done_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic master_read_request;
    logic ack_received;
  } i2sp_flags_type;
endpackage : i2sp_pkg

// ### bench/i2sp_master_model.sv
// Purpose: Behavioural I2C bus master for the slave port bench
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes: Bus clock 200 ns, low 100 ns then high 100 ns
`timescale 1ns/1ps
module i2sp_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // ==========================================
  // Bus conditions
  task automatic start();
    #100 sda_low = 1'b1;
    #100 scl_low = 1'b1;
  endtask : start
  task automatic stop();
    #30 sda_low = 1'b1;
    #70 scl_low = 1'b0;
    #100 sda_low = 1'b0;
    #200;
  endtask : stop
  // One clock; g adds a 20 ns low glitch and stretches the high phase past the filter
  task automatic xbit(input logic b, input logic g, output logic r);
    #30 sda_low = ~b;
    #70 scl_low = 1'b0;
    if (g) begin
      #30 scl_low = 1'b1;
      #20 scl_low = 1'b0;
      #140;
    end else begin
      #90;
    end
    r = sda;
    #10 scl_low = 1'b1;
  endtask : xbit
  task automatic xbyte(input logic [7:0] d, input logic g, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], g && (i == 5), q[i]);
    end
    xbit(1'b1, 1'b0, ack);
  endtask : xbyte
endmodule : i2sp_master_model

// ### bench/test_i2sp_slave.sv
// Purpose: Self-checking bench for the I2C slave port
// Assumes: mclk 40 MHz, master model clocks the bus at 200 ns
// Notes: Register strobes change by non-blocking assignment after mclk rise
`timescale 1ns/1ps
`include "i2sp_defs.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module test_i2sp_slave;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic scl_out_ff, scl_oe_ff, sda_out_ff, sda_oe_ff, irq_ff, m_scl_low, m_sda_low, ack;
  logic [1:0] pullup_en_ff;
  logic [7:0] q;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  wire scl_line = ~(m_scl_low | (scl_oe_ff & ~scl_out_ff));
  wire sda_line = ~(m_sda_low | (sda_oe_ff & ~sda_out_ff));
  i2sp_slave dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .scl_in(scl_line),
    .scl_out_ff(scl_out_ff), .scl_oe_ff(scl_oe_ff), .sda_in(sda_line), .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff), .pullup_en_ff(pullup_en_ff), .irq_ff(irq_ff));
  i2sp_master_model mst (.scl(scl_line), .sda(sda_line), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // ==========================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, ex, reg_rdata_ff)
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic close_out();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk) begin
    cycles++;
    if (rst_b) `CHK("od_drive", 3'h0, {scl_out_ff, sda_out_ff, scl_oe_ff})
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(`I2SP_OFS_MODE, 8'he0, "mode_rst");
    rd(`I2SP_OFS_ADDR, 8'h00, "addr_rst");
    rd(`I2SP_OFS_STAT, 8'h81, "flag_rst");
    rd(8'h40, 8'h00, "unmapped");
    for (int c = 0; c < 8; c++) begin
      wr(`I2SP_OFS_MODE, {c[2:0], 5'h1d});
      rd(`I2SP_OFS_MODE, {c[2:0], 5'h0d}, "func");
    end
    wr(`I2SP_OFS_ADDR, 8'hb5);
    rd(`I2SP_OFS_ADDR, 8'hb5, "own_addr");
    wr(`I2SP_OFS_TOUT, 8'h5c);
    rd(`I2SP_OFS_TOUT, 8'h5c, "tout");
    wr(`I2SP_OFS_MODE, 8'hc6);
    wr(`I2SP_OFS_PULLUP, 8'h03);
    settle();
    `CHK("pullup", 2'h3, pullup_en_ff)
  endtask : t_regs
  task automatic t_write();
    wr(`I2SP_OFS_IRQ_MASK, 8'h00);
    mst.start();
    mst.xbyte(8'hb4, 1'b0, q, ack);
    `CHK("addr_ack", 1'b0, ack)
    mst.xbyte(8'h3c, 1'b0, q, ack);
    `CHK("data_ack", 1'b0, ack)
    mst.stop();
    rd(`I2SP_OFS_DATA, 8'h3c, "rx_data");
    rd(`I2SP_OFS_IRQ_STAT, 8'h07, "irq_stat");
    `CHK("irq_masked", 1'b0, irq_ff)
    wr(`I2SP_OFS_IRQ_MASK, 8'h07);
    settle();
    `CHK("irq_on", 1'b1, irq_ff)
    wr(`I2SP_OFS_IRQ_STAT, 8'h07);
    settle();
    `CHK("irq_off", 1'b0, irq_ff)
    mst.start();
    mst.xbyte(8'hb6, 1'b0, q, ack);
    `CHK("other_addr", 1'b1, ack)
    mst.stop();
  endtask : t_write
  task automatic t_filter();
    for (int d = 1; d < 4; d++) begin
      wr(`I2SP_OFS_MODE, {3'h6, 1'b0, d[1:0], 2'h2});
      mst.start();
      mst.xbyte(8'hb4, 1'b1, q, ack);
      `CHK("glitch_ack", 1'b0, ack)
      mst.stop();
    end
    wr(`I2SP_OFS_MODE, 8'ha6);
    mst.start();
    mst.xbyte(8'hb4, 1'b0, q, ack);
    `CHK("spi_mode_ack", 1'b1, ack)
    mst.stop();
    wr(`I2SP_OFS_MODE, 8'hc6);
  endtask : t_filter
  task automatic t_read();
    wr(`I2SP_OFS_STAT, 8'h10);
    mst.start();
    for (int i = 7; i >= 0; i--) begin
      mst.xbit(((8'hb5 >> i) & 8'h01) != 8'h00, 1'b0, q[i]);
    end
    fork
      mst.xbit(1'b1, 1'b0, ack);
      begin
        #150 wr(`I2SP_OFS_DATA, 8'h96);
      end
    join
    `CHK("rd_addr_ack", 1'b0, ack)
    mst.xbyte(8'hff, 1'b0, q, ack);
    `CHK("tx_data", 8'h96, q)
    mst.stop();
    wr(`I2SP_OFS_STAT, 8'h18);
    wr(`I2SP_OFS_MODE, 8'hc4);
    wr(`I2SP_OFS_MODE, 8'hc6);
    rd(`I2SP_OFS_STAT, 8'h99, "en_rise");
  endtask : t_read
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_write();
    t_filter();
    t_read();
    close_out();
  end
endmodule : test_i2sp_slave
